// ### hw/ctdc_acq_ctrl.sv
// event fifo and acquisition control of the common-stop single-word tdc
// assumes converter hits arrive synchronous to sys_clk_i, one command per cycle
//
// Contract
// R1 - reg0 low byte: module id in header
// R2 - reg0 bits 8-9 select data shift
// R3 - reg0 bit 10: both edges or leading
// R4 - reg0 bit 11 routes readout to port
// R5 - reg0 bit 12 enables multi-event buffering
// R6 - reg0 bit 13 skips header on empty events
// R7 - reg0 bits 14-15 read zero
// R8 - reg1 trigger pulse width and delay fields
// R9 - reg1 bits 8-9 trigger clock unit
// R10 - reg1 bits 10-11 pause interval length
// R11 - reg1 bit 12 selects fast port readout
// R12 - serial number in header, counts events
// R13 - per-channel hit limit, zero means 16
// R14 - drop hits above full-scale upper bits
// R15 - request delay in 2 us steps
// R16 - subtract offset, drop hits below it
// R17 - software keeps offset inside valid window
// R18 - busy and busy test during transfer
// R19 - single buffer: busy until read out
// R20 - trigger waits full range after busy; here a stop in idle is taken at once
// R21 - clear honoured only inside pause interval
// R22 - clear input synchronised to system clock
// R23 - clear-all erases data, keeps registers
// R24 - registers by subaddress read and write
// R25 - accepted clear drops the whole event
`timescale 1ns/10ps

// parameterised event buffer with a registered output word
module ctdc_fifo #(
    parameter int W = 16,
    parameter int D = 32
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         flush_i,     // drop all content
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    input  wire logic         hold_i,      // block loads into the output stage
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i,
    output logic              empty_o      // nothing stored at all
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];               // storage array
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0]   count_reg;
    wire           push = in_valid_i && in_ready_o;
    wire           take = out_valid_o && out_ready_i;
    // output stage reloads when free or drained, unless held
    wire           load = (!out_valid_o || out_ready_i) && (count_reg != '0) && !hold_i;

    assign in_ready_o = (count_reg != (AW+1)'(D)); // honest full
    assign empty_o    = (count_reg == '0) && !out_valid_o;

    // storage write, no reset needed on data
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    // pointers, count and output stage
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_reg  <= '0;
            rd_ptr_reg  <= '0;
            count_reg   <= '0;
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end else if (flush_i) begin
            wr_ptr_reg  <= '0;
            rd_ptr_reg  <= '0;
            count_reg   <= '0;
            out_valid_o <= 1'b0;
        end else begin
            wr_ptr_reg <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
            rd_ptr_reg <= load ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
            count_reg  <= count_reg + (AW+1)'(push) - (AW+1)'(load);
            if (load) begin
                out_valid_o <= 1'b1;
                out_data_o  <= mem[rd_ptr_reg];
            end else if (take) begin
                out_valid_o <= 1'b0;
            end
        end
    end
endmodule // ctdc_fifo

module ctdc_acq_ctrl
    import ctdc_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    input  wire logic        cmd_valid_i,        // one crate bus command
    input  wire ctdc_cmd_t   cmd_i,
    output logic             rsp_valid_o,        // answer to a command
    output logic [15:0]      rsp_data_o,
    output logic             rsp_q_o,
    input  wire logic        common_stop_i,      // front-panel stop pulse
    input  wire logic        clear_i,            // front-panel clear, async
    input  wire logic        hit_valid_i,        // converter dump stream
    input  wire ctdc_hit_t   hit_i,
    output logic             hit_ready_o,
    output logic             xfer_start_o,       // pulse: start dump
    output logic             event_drop_o,       // pulse: event cleared
    output logic             busy_o,
    output logic             rd_valid_o,         // event word stream
    output logic [15:0]      rd_data_o,
    input  wire logic        rd_ready_i,
    output logic             ecl_port_readout_o, // readout path select
    output logic             fast_readout_o,
    output logic [3:0]       trig_width_o,
    output logic [3:0]       trig_delay_o,
    output logic [1:0]       trig_unit_o
);
    logic [13:0]  acq_reg;             // writable part of reg0
    logic [15:0]  trig_reg;            // reg1, serial in top bits
    logic [15:0]  lim_reg;             // reg2
    logic [15:0]  req_reg;             // reg3
    ctdc_state_t  state_reg;
    ctdc_state_t  state_next;
    logic [5:0]   pause_cnt_reg;       // cycles left of the pause
    logic [8:0]   req_cnt_reg;         // cycles left of request delay
    logic         clr_s1_reg;          // synchroniser, first stage
    logic         clr_s2_reg;          // synchroniser, second stage
    logic         hdr_sent_reg;        // header already pushed
    logic         stg_valid_reg;       // one-hit staging register
    ctdc_hit_t    stg_reg;
    logic [4:0]   hit_cnt [CHANNELS];  // accepted hits per channel
    logic         fifo_in_ready;
    logic         fifo_empty;

    // pause length decode, used by the counter load
    function automatic logic [5:0] pause_cyc(input logic [1:0] sel);
        case (sel)
            2'h1:    pause_cyc = 6'(PAUSE1_CYC);
            2'h2:    pause_cyc = 6'(PAUSE2_CYC);
            2'h3:    pause_cyc = 6'(PAUSE3_CYC);
            default: pause_cyc = 6'h00;
        endcase
    endfunction

    // command decode
    wire        cmd_wr   = cmd_valid_i && (cmd_i.func == FUNC_REGISTER_WRITE);
    wire        cmd_clr  = cmd_valid_i && (cmd_i.func == FUNC_CLEAR_ALL);
    wire        wr_trig  = cmd_wr && (cmd_i.sub == SUB_TRIG);
    // configuration fields
    wire [7:0]  mod_id   = acq_reg[ACQ_ID_LSB +: 8];
    wire [1:0]  shift    = acq_reg[ACQ_SHIFT_LSB +: 2];
    wire        both     = acq_reg[ACQ_BOTH_BIT];
    wire        multi    = acq_reg[ACQ_MULTI_BIT];
    wire        skip_hdr = acq_reg[ACQ_SKIP_BIT];
    wire [1:0]  pause_sel = trig_reg[TRIG_PAUSE_LSB +: 2];
    wire [2:0]  serial   = trig_reg[TRIG_SER_LSB +: 3];
    wire [3:0]  hits_fld = lim_reg[LIM_HITS_LSB +: 4];
    wire [4:0]  hit_lim  = (hits_fld == 4'h0) ? HITS_MAX : {1'b0, hits_fld}; // see R13
    wire [11:0] scale    = lim_reg[LIM_SCALE_LSB +: 12];
    wire [15:0] offset   = {req_reg[REQ_OFS_LSB +: 12], 4'h0};          // see R16
    wire [8:0]  req_load = 9'(req_reg[REQ_DLY_LSB +: 4] * REQ_STEP_CYC); // see R15

    // hit filter on the staged hit
    wire        range_ok = (stg_reg.stamp[15:4] <= scale);              // see R14
    wire        ofs_ok   = (stg_reg.stamp >= offset);                   // see R16
    wire        edge_ok  = both || !stg_reg.trailing;                   // see R3
    wire        lim_ok   = (hit_cnt[stg_reg.chan] < hit_lim);           // see R13
    wire        keep     = range_ok && ofs_ok && edge_ok && lim_ok;
    wire [15:0] diff     = stg_reg.stamp - offset;                      // see R16
    wire [15:0] shifted  = diff >> shift;                               // see R2
    wire [9:0]  tval     = both ? {shifted[8:0], stg_reg.trailing} : shifted[9:0];
    wire [15:0] dat_word = {1'b0, stg_reg.chan, tval};
    wire [15:0] hdr_word = {1'b1, serial, 4'h0, mod_id};                // see R1, R12
    // push sequencing: header goes ahead of the first kept word
    wire        is_end   = stg_reg.last;
    wire        hdr_want = stg_valid_reg && !hdr_sent_reg && (is_end ? !skip_hdr : keep); // see R6
    wire        dat_want = stg_valid_reg && !is_end && keep && hdr_sent_reg;
    wire        push     = hdr_want || dat_want;
    wire        fire     = push && fifo_in_ready;
    wire        consume  = stg_valid_reg && (is_end ? (!hdr_want || fire) : (!keep || (dat_want && fire)));
    wire        end_done = consume && is_end;
    wire        take     = hit_valid_i && hit_ready_o;
    wire        stg_next = (state_next == ST_XFER) && (take || (stg_valid_reg && !consume));
    // clear accepted only inside a nonzero pause window
    wire        clr_hit  = (state_reg == ST_PAUSE) && clr_s2_reg;        // see R21, R25
    // single-buffer readout waits out the request delay
    wire        rd_hold  = !multi && !((state_reg == ST_HOLD) && (req_cnt_reg == 9'h000)); // see R5, R15

    // register readback mux
    wire [15:0] rd_mux = (cmd_i.sub == SUB_ACQ)  ? {PROGRAM_LOAD, acq_reg} : // see R7
                         (cmd_i.sub == SUB_TRIG) ? trig_reg :
                         (cmd_i.sub == SUB_LIM)  ? lim_reg : req_reg;

    // event sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                // stops during busy never reach here, so they are ignored
                if (common_stop_i) begin
                    state_next = (pause_sel != 2'h0) ? ST_PAUSE : ST_XFER; // see R10, R18
                end
            end
            ST_PAUSE: begin
                if (clr_hit) begin
                    state_next = ST_IDLE;                               // see R25
                end else if (pause_cnt_reg == 6'h01) begin
                    state_next = ST_XFER;                               // see R10
                end
            end
            ST_XFER: begin
                if (end_done) begin
                    state_next = multi ? ST_IDLE : ST_HOLD;             // see R5, R19
                end
            end
            ST_HOLD: begin
                // held until the event is fully read, or erased
                if (cmd_clr || (fifo_empty && (req_cnt_reg == 9'h000))) begin
                    state_next = ST_IDLE;                               // see R19, R23
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // control registers; a write beats a same-cycle serial step
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            acq_reg  <= ACQ_RESET[13:0];
            trig_reg <= TRIG_RESET;
            lim_reg  <= LIM_RESET;
            req_reg  <= REQ_RESET;
        end else begin
            if (cmd_wr && (cmd_i.sub == SUB_ACQ)) begin
                acq_reg <= cmd_i.wdata[13:0];                           // see R24
            end
            if (wr_trig) begin
                trig_reg <= cmd_i.wdata;                                // see R24, R12
            end else if (cmd_clr) begin
                trig_reg[TRIG_SER_LSB +: 3] <= 3'h0;                    // see R23
            end else if (end_done) begin
                trig_reg[TRIG_SER_LSB +: 3] <= serial + 3'h1;           // see R12
            end
            if (cmd_wr && (cmd_i.sub == SUB_LIM)) begin
                lim_reg <= cmd_i.wdata;
            end
            if (cmd_wr && (cmd_i.sub == SUB_REQ)) begin
                req_reg <= cmd_i.wdata;
            end
        end
    end

    // command answers
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rsp_valid_o <= 1'b0;
            rsp_data_o  <= 16'h0000;
            rsp_q_o     <= 1'b0;
        end else begin
            rsp_valid_o <= cmd_valid_i;
            rsp_data_o  <= (cmd_i.func == FUNC_REGISTER_READ) ? rd_mux : 16'h0000;
            rsp_q_o     <= (cmd_i.func == FUNC_BUSY_TEST) ? busy_o : 1'b1; // see R18
        end
    end

    // clear synchroniser, plain two stages
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            clr_s1_reg <= 1'b0;
            clr_s2_reg <= 1'b0;
        end else begin
            clr_s1_reg <= clear_i;                                      // see R22
            clr_s2_reg <= clr_s1_reg;
        end
    end

    // state, counters and status outputs
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg     <= ST_IDLE;
            pause_cnt_reg <= 6'h00;
            req_cnt_reg   <= 9'h000;
            busy_o        <= 1'b0;
            xfer_start_o  <= 1'b0;
            event_drop_o  <= 1'b0;
        end else begin
            state_reg     <= state_next;
            pause_cnt_reg <= (state_reg == ST_IDLE) ? pause_cyc(pause_sel) : pause_cnt_reg - 6'h01;
            if ((state_reg == ST_XFER) && (state_next == ST_HOLD)) begin
                req_cnt_reg <= req_load;                                // see R15
            end else if ((state_reg == ST_HOLD) && (req_cnt_reg != 9'h000)) begin
                req_cnt_reg <= req_cnt_reg - 9'h001;
            end
            busy_o        <= (state_next != ST_IDLE);                   // see R18, R19
            xfer_start_o  <= (state_next == ST_XFER) && (state_reg != ST_XFER);
            event_drop_o  <= clr_hit;                                   // see R25
        end
    end

    // hit staging and header bookkeeping
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            stg_valid_reg <= 1'b0;
            stg_reg       <= '0;
            hit_ready_o   <= 1'b0;
            hdr_sent_reg  <= 1'b0;
        end else begin
            stg_valid_reg <= stg_next;
            hit_ready_o   <= (state_next == ST_XFER) && !stg_next;
            if (take) begin
                stg_reg <= hit_i;
            end
            if (state_reg != ST_XFER) begin
                hdr_sent_reg <= 1'b0;
            end else if (fire && hdr_want) begin
                hdr_sent_reg <= 1'b1;
            end
        end
    end

    // per-channel hit counters, restarted for each event
    for (genvar c = 0; c < CHANNELS; c++) begin : g_cnt
        always_ff @(posedge sys_clk_i or posedge reset_i) begin
            if (reset_i) begin
                hit_cnt[c] <= 5'h00;
            end else if (state_reg != ST_XFER) begin
                hit_cnt[c] <= 5'h00;
            end else if (dat_want && fire && (stg_reg.chan == 5'(c))) begin
                hit_cnt[c] <= hit_cnt[c] + 5'h01;                       // see R13
            end
        end
    end

    // the event buffer itself; a full buffer stalls the dump
    ctdc_fifo #(
        .W (WORD_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (sys_clk_i),
        .rst_i       (reset_i),
        .flush_i     (cmd_clr),                                         // see R23
        .in_valid_i  (push),
        .in_data_i   (hdr_want ? hdr_word : dat_word),
        .in_ready_o  (fifo_in_ready),
        .hold_i      (rd_hold),
        .out_valid_o (rd_valid_o),
        .out_data_o  (rd_data_o),
        .out_ready_i (rd_ready_i),
        .empty_o     (fifo_empty)
    );

    // configuration straight from register bits
    assign ecl_port_readout_o = acq_reg[ACQ_ECL_BIT];                   // see R4
    assign fast_readout_o     = trig_reg[TRIG_FAST_BIT];                // see R11
    assign trig_width_o       = trig_reg[TRIG_WID_LSB +: 4];            // see R8
    assign trig_delay_o       = trig_reg[TRIG_DLY_LSB +: 4];            // see R8
    assign trig_unit_o        = trig_reg[TRIG_UNIT_LSB +: 2];           // see R9

    a_load_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i) // see R7
        cmd_valid_i && (cmd_i.func == FUNC_REGISTER_READ) && (cmd_i.sub == SUB_ACQ)
        |=> rsp_valid_o && (rsp_data_o[15:14] == 2'h0))
        else $error("program load bits not zero");
    a_reg_readback: assert property (@(posedge sys_clk_i) disable iff (reset_i) // see R24
        cmd_valid_i && (cmd_i.func == FUNC_REGISTER_WRITE) && (cmd_i.sub == SUB_LIM)
        ##1 cmd_valid_i && (cmd_i.func == FUNC_REGISTER_READ) && (cmd_i.sub == SUB_LIM)
        |=> rsp_data_o == $past(cmd_i.wdata, 2))
        else $error("register readback mismatch");
    a_busy_answer: assert property (@(posedge sys_clk_i) disable iff (reset_i) // see R18
        cmd_valid_i && (cmd_i.func == FUNC_BUSY_TEST) |=> rsp_q_o == $past(busy_o))
        else $error("busy test answer wrong");
    a_clear_window: assert property (@(posedge sys_clk_i) disable iff (reset_i) // see R21
        $rose(event_drop_o) |-> ($past(state_reg) == ST_PAUSE) && ($past(pause_sel) != 2'h0))
        else $error("clear taken outside pause");
    a_no_pause: assert property (@(posedge sys_clk_i) disable iff (reset_i) // see R10
        (state_reg == ST_IDLE) && common_stop_i && (pause_sel == 2'h0)
        |=> (state_reg == ST_XFER) && busy_o)
        else $error("stop without pause not to transfer");
    a_pause_len: assert property (@(posedge sys_clk_i) disable iff (reset_i) // see R10
        (state_reg == ST_IDLE) && common_stop_i && (pause_sel == 2'h1)
        ##1 ((state_reg == ST_PAUSE) && !clr_s2_reg)[*8] |=> state_reg == ST_XFER)
        else $error("pause interval length wrong");
    a_hold_busy: assert property (@(posedge sys_clk_i) disable iff (reset_i) // see R19
        (state_reg == ST_HOLD) && !fifo_empty && !cmd_clr |=> busy_o)
        else $error("busy dropped before readout");
    a_serial_step: assert property (@(posedge sys_clk_i) disable iff (reset_i) // see R12
        end_done && !wr_trig && !cmd_clr |=> serial == $past(serial) + 3'h1)
        else $error("serial not advanced");
    a_clear_all: assert property (@(posedge sys_clk_i) disable iff (reset_i) // see R23
        cmd_clr |=> (serial == 3'h0) && (lim_reg == $past(lim_reg)) && !rd_valid_o)
        else $error("clear-all effect wrong");
    a_offset_drop: assert property (@(posedge sys_clk_i) disable iff (reset_i) // see R16
        stg_valid_reg && !is_end && (stg_reg.stamp < offset) |-> !dat_want)
        else $error("hit below offset stored");
    a_range_drop: assert property (@(posedge sys_clk_i) disable iff (reset_i) // see R14
        dat_want |-> stg_reg.stamp <= {scale, 4'hF})
        else $error("hit above full scale stored");
endmodule // ctdc_acq_ctrl

// ### hw/ctdc_pkg.sv
// common-stop single-word acquisition control: shared constants and types
// assumes a 100 ns system clock and one command at a time from the crate bus
package ctdc_pkg;
    localparam int CLK_NS     = 100;  // system clock period, ns
    localparam int WORD_W     = 16;   // event word width
    localparam int FIFO_DEPTH = 32;   // event buffer depth, words
    localparam int CHANNELS   = 32;   // input channels

    // register subaddresses
    localparam logic [1:0] SUB_ACQ  = 2'h0;
    localparam logic [1:0] SUB_TRIG = 2'h1;
    localparam logic [1:0] SUB_LIM  = 2'h2;
    localparam logic [1:0] SUB_REQ  = 2'h3;

    // values after reset
    localparam logic [15:0] ACQ_RESET  = 16'h0000;
    localparam logic [15:0] TRIG_RESET = 16'h0000;
    localparam logic [15:0] LIM_RESET  = 16'hFFFF;
    localparam logic [15:0] REQ_RESET  = 16'h0000;

    // field positions
    localparam int ACQ_ID_LSB     = 0;
    localparam int ACQ_SHIFT_LSB  = 8;
    localparam int ACQ_BOTH_BIT   = 10;
    localparam int ACQ_ECL_BIT    = 11;
    localparam int ACQ_MULTI_BIT  = 12;
    localparam int ACQ_SKIP_BIT   = 13;
    localparam int TRIG_WID_LSB   = 0;
    localparam int TRIG_DLY_LSB   = 4;
    localparam int TRIG_UNIT_LSB  = 8;
    localparam int TRIG_PAUSE_LSB = 10;
    localparam int TRIG_FAST_BIT  = 12;
    localparam int TRIG_SER_LSB   = 13;
    localparam int LIM_HITS_LSB   = 0;
    localparam int LIM_SCALE_LSB  = 4;
    localparam int REQ_DLY_LSB    = 0;
    localparam int REQ_OFS_LSB    = 4;

    localparam logic [1:0] PROGRAM_LOAD = 2'h0;  // this configuration's load code
    localparam logic [4:0] HITS_MAX     = 5'h10; // field value zero means this

    // pause interval and request delay timing
    localparam int PAUSE1_NS    = 800;
    localparam int PAUSE2_NS    = 1600;
    localparam int PAUSE3_NS    = 3200;
    localparam int PAUSE1_CYC   = (PAUSE1_NS + CLK_NS - 1) / CLK_NS;
    localparam int PAUSE2_CYC   = (PAUSE2_NS + CLK_NS - 1) / CLK_NS;
    localparam int PAUSE3_CYC   = (PAUSE3_NS + CLK_NS - 1) / CLK_NS;
    localparam int REQ_STEP_US  = 2;
    localparam int REQ_STEP_CYC = (REQ_STEP_US * 1000 + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        FUNC_REGISTER_READ, FUNC_REGISTER_WRITE, FUNC_CLEAR_ALL, FUNC_BUSY_TEST
    } ctdc_func_t;

    typedef struct packed {
        ctdc_func_t  func;
        logic [1:0]  sub;
        logic [15:0] wdata;
    } ctdc_cmd_t;

    typedef struct packed {
        logic        last;     // end-of-dump marker, carries no hit
        logic        trailing; // trailing-edge hit
        logic [4:0]  chan;
        logic [15:0] stamp;    // raw time, 0.5 ns counts
    } ctdc_hit_t;

    typedef enum logic [1:0] {ST_IDLE, ST_PAUSE, ST_XFER, ST_HOLD} ctdc_state_t;
endpackage

// ### test/ctdc_conv_model.sv
// converter dump model: plays four hits, then an end marker, per dump request
// assumes the dump request is a one-cycle pulse on the system clock
`timescale 1ns/10ps
module ctdc_conv_model
    import ctdc_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            start_i, // dump request
    input  wire ctdc_hit_t [3:0] hits_i,  // hits of this event
    input  wire logic            ready_i,
    output logic                 valid_o,
    output ctdc_hit_t            hit_o
);
    logic [2:0] idx_reg; // slot to present next
    // after the end marker the lines show the inverse, never a stale hit
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            idx_reg <= 3'h0;
            valid_o <= 1'b0;
            hit_o   <= '0;
        end else if (start_i) begin
            idx_reg <= 3'h1;
            valid_o <= 1'b1;
            hit_o   <= hits_i[0];
        end else if (valid_o && ready_i) begin
            idx_reg <= idx_reg + 3'h1;
            valid_o <= (idx_reg != 3'h5);
            hit_o   <= (idx_reg == 3'h4) ? ctdc_hit_t'({1'b1, 22'h00_0000}) :
                       (idx_reg == 3'h5) ? ctdc_hit_t'(~hit_o) : hits_i[idx_reg[1:0]];
        end
    end
endmodule // ctdc_conv_model

// ### test/ctdc_acq_ctrl_tb_top.sv
// top testbench: register access, one filtered event, one cleared event
// assumes design and converter model share sys_clk_i; readout stalls only in the single-buffer part of the clear test
`timescale 1ns/10ps
module ctdc_acq_ctrl_tb_top;
    import ctdc_pkg::*;
    logic            sys_clk_i = 1'b0, reset_i = 1'b1, cmd_valid_i = 1'b0;
    logic            common_stop_i = 1'b0, clear_i = 1'b0, rd_ready_i = 1'b1;
    logic            hit_valid, hit_ready, xfer, drop, busy, rsp_valid, rsp_q, rd_valid, ecl, fast;
    logic [15:0]     rsp_data, rd_data;
    logic [3:0]      tw, td;
    logic [1:0]      tu;
    ctdc_cmd_t       cmd_i = '0;
    ctdc_hit_t       hit;
    ctdc_hit_t [3:0] hits = '0;
    logic [15:0]     words[$]; // event words seen
    int              err_count = 0, compares = 0, cyc = 0;
    always #50 sys_clk_i = ~sys_clk_i;
    ctdc_acq_ctrl dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
        .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_q_o(rsp_q), .common_stop_i(common_stop_i),
        .clear_i(clear_i), .hit_valid_i(hit_valid), .hit_i(hit), .hit_ready_o(hit_ready),
        .xfer_start_o(xfer), .event_drop_o(drop), .busy_o(busy), .rd_valid_o(rd_valid),
        .rd_data_o(rd_data), .rd_ready_i(rd_ready_i), .ecl_port_readout_o(ecl),
        .fast_readout_o(fast), .trig_width_o(tw), .trig_delay_o(td), .trig_unit_o(tu));
    ctdc_conv_model conv_u (.clk_i(sys_clk_i), .rst_i(reset_i), .start_i(xfer), .hits_i(hits),
        .ready_i(hit_ready), .valid_o(hit_valid), .hit_o(hit));
    always @(posedge sys_clk_i) if (rd_valid && rd_ready_i) words.push_back(rd_data);
    // hang guard, far above the hundred-odd cycles the tests need
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic cmd(ctdc_func_t f, logic [1:0] s, logic [15:0] w);
        @(negedge sys_clk_i);
        cmd_i = '{f, s, w};
        cmd_valid_i = 1'b1;
        @(negedge sys_clk_i);
        chk("answer", 16'(rsp_valid), 16'h0001);
        cmd_valid_i = 1'b0;
    endtask
    task automatic stop();
        words.delete();
        @(negedge sys_clk_i);
        common_stop_i = 1'b1;
        @(negedge sys_clk_i);
        common_stop_i = 1'b0;
    endtask
    task automatic t_regs();
        logic [15:0] exp[4] = '{16'h0000, 16'h0000, 16'hFFFF, 16'h0000};
        for (int i = 0; i < 4; i++) begin
            cmd(FUNC_REGISTER_READ, 2'(i), 16'h0000);
            chk("reset value", rsp_data, exp[i]);
        end
        cmd(FUNC_REGISTER_WRITE, SUB_ACQ, 16'hFFFF);
        cmd(FUNC_REGISTER_READ, SUB_ACQ, 16'h0000);
        chk("acq readback", rsp_data, 16'h3FFF);
        chk("ecl path", 16'(ecl), 16'h0001);
        cmd(FUNC_REGISTER_WRITE, SUB_TRIG, 16'h17A5);
        cmd(FUNC_REGISTER_READ, SUB_TRIG, 16'h0000);
        chk("trig readback", rsp_data, 16'h17A5);
        chk("trig fields", 16'({fast, tu, td, tw}), 16'h07A5);
        $display("register test done");
    endtask
    task automatic t_event();
        cmd(FUNC_REGISTER_WRITE, SUB_ACQ, 16'h115A);
        cmd(FUNC_REGISTER_WRITE, SUB_TRIG, 16'h0000);
        cmd(FUNC_REGISTER_WRITE, SUB_LIM, 16'h0101);
        cmd(FUNC_REGISTER_WRITE, SUB_REQ, 16'h0010); // offset inside the window
        hits[0] = {2'b00, 5'h03, 16'h010F};
        hits[1] = {2'b00, 5'h03, 16'h0106};
        hits[2] = {2'b00, 5'h05, 16'h0008};
        hits[3] = {2'b00, 5'h06, 16'h0110};
        stop();
        clear_i = 1'b1; // no pause, so this must not cut the event
        cmd(FUNC_BUSY_TEST, SUB_ACQ, 16'h0000);
        chk("busy test", 16'(rsp_q), 16'h0001);
        for (int i = 0; i < 60 && busy; i++) @(negedge sys_clk_i);
        clear_i = 1'b0;
        chk("word count", 16'(words.size()), 16'h0002);
        chk("header", words[0], 16'h805A);
        chk("data", words[1], 16'h0C7F);
        cmd(FUNC_BUSY_TEST, SUB_ACQ, 16'h0000);
        chk("idle test", 16'(rsp_q), 16'h0000);
        cmd(FUNC_REGISTER_READ, SUB_TRIG, 16'h0000);
        chk("serial", rsp_data, 16'h2000);
        $display("event test done");
    endtask
    task automatic t_clear();
        cmd(FUNC_REGISTER_WRITE, SUB_TRIG, 16'h2400);
        stop();
        @(negedge sys_clk_i);
        clear_i = 1'b1; // well after the stop edge
        for (int i = 0; i < 12 && !drop; i++) @(negedge sys_clk_i);
        chk("event dropped", 16'(drop), 16'h0001);
        clear_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        chk("busy after clear", 16'(busy), 16'h0000);
        chk("no words", 16'(words.size()), 16'h0000);
        cmd(FUNC_CLEAR_ALL, SUB_ACQ, 16'h0000);
        cmd(FUNC_REGISTER_READ, SUB_TRIG, 16'h0000);
        chk("serial cleared", rsp_data, 16'h0400);
        cmd(FUNC_REGISTER_WRITE, SUB_ACQ, 16'h015A); // single buffer
        rd_ready_i = 1'b0;
        stop(); // long after busy fell
        repeat (40) @(negedge sys_clk_i);
        chk("held busy", 16'({busy, rd_valid}), 16'h0003);
        rd_ready_i = 1'b1;
        for (int i = 0; i < 20 && busy; i++) @(negedge sys_clk_i);
        chk("single words", 16'(words.size()), 16'h0002);
        $display("clear test done");
    endtask
    task automatic tally_and_finish();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge sys_clk_i);
        reset_i = 1'b0;
        t_regs();
        t_event();
        t_clear();
        tally_and_finish();
    end
endmodule // ctdc_acq_ctrl_tb_top
